// ### shared/pager_pkt_pkg.sv
// Shared constants for the decoder-to-host packet framer.
// Assumes one 100 MHz system clock and a 32-bit AHB-Lite register bus.
`default_nettype none
package pager_pkt_pkg;
  localparam int PKT_BITS     = 32;
  localparam int TX_BUF_DEPTH = 32;

  // Register byte offsets
  localparam logic [7:0] OFS_CONTROL  = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_SHUTDOWN = 8'h08;
  localparam logic [7:0] OFS_ROAMING  = 8'h0C;
  localparam logic [7:0] OFS_STAT_PKT = 8'h10;

  // Control register fields
  localparam int CTL_DECODER_ON   = 0;
  localparam int CTL_TIME_FWD     = 1;
  localparam int CTL_ALL_FWD      = 2;
  localparam int CTL_MANUAL_COLL  = 3;
  localparam int CTL_CHK_DISABLED = 4;
  localparam int CTL_WIDTH        = 5;

  // Status register fields
  localparam int STS_STOPPED      = 0;
  localparam int STS_SHUT_PEND    = 1;
  localparam int STS_ROAM_PEND    = 2;
  localparam int STS_COUNT_LSB    = 8;

  // Packet identifiers and error threshold
  localparam logic [7:0] ID_BIW  = 8'h00;
  localparam logic [7:0] ID_ADDR = 8'h01;
  localparam logic [2:0] MAX_CORRECTED = 3'h2;

  // Block information word format types
  localparam logic [2:0] FMT_LOCAL_ID = 3'h0;
  localparam logic [2:0] FMT_DATE     = 3'h1;
  localparam logic [2:0] FMT_TIME     = 3'h2;
  localparam logic [2:0] FMT_SYS_MSG  = 3'h5;
  localparam logic [2:0] FMT_COUNTRY  = 3'h7;

  typedef enum logic [2:0] {SRC_PART_ID, SRC_SHUTDOWN, SRC_ROAMING, SRC_BUFFER, SRC_STATUS}
    pkt_src_t;

  // Formats that may leave the block with the error flag clear
  function automatic logic is_time_format(input logic [2:0] fmt);
    return (fmt == FMT_DATE) || (fmt == FMT_TIME) || (fmt == FMT_SYS_MSG);
  endfunction

  function automatic logic word_in_error(input logic [2:0] errs, input logic chk_fail);
    return (errs > MAX_CORRECTED) || chk_fail;
  endfunction
endpackage
`default_nettype wire

// ### hdl/pkt_fifo.sv
// Packet transmit buffer built from flip-flops, with flush.
// Push while full is ignored; the owner handles overflow.
`default_nettype none
module pkt_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  input  wire logic                       hclk,
  input  wire logic                       hresetn,
  input  wire logic                       push,
  input  wire logic [WIDTH-1:0]           push_data,
  input  wire logic                       pop,
  input  wire logic                       flush,
  output logic      [WIDTH-1:0]           head,
  output logic      [$clog2(DEPTH+1)-1:0] count,
  output logic                            empty,
  output logic                            full
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    rd_ptr;
  logic [PW-1:0]    wr_ptr;
  logic             do_push;
  logic             do_pop;

  assign do_push = push && !full;
  assign do_pop  = pop && !empty;
  assign empty   = (count == '0);
  assign full    = (count == ($clog2(DEPTH+1))'(DEPTH));
  assign head    = mem[rd_ptr];

  always_ff @(posedge hclk) begin
    if (do_push) begin
      mem[wr_ptr] <= push_data;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_ptr <= '0;
      wr_ptr <= '0;
      count  <= '0;
    end else if (flush) begin
      rd_ptr <= '0;
      wr_ptr <= '0;
      count  <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (do_pop) begin
        rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      if (do_push && !do_pop) begin
        count <= count + 1'b1;
      end else if (do_pop && !do_push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ### hdl/spi_pkt_shifter.sv
// SPI slave transmit shifter: one 32-bit packet per chip-select frame.
// Assumes sck idles low; host samples on rising edge, data changes on falling.
`default_nettype none
module spi_pkt_shifter #(
  parameter int BITS = 32
) (
  input  wire logic            hclk,
  input  wire logic            hresetn,
  input  wire logic            spi_sck,
  input  wire logic            spi_cs_n,
  input  wire logic [BITS-1:0] tx_word,
  output logic                 load_req,
  output logic                 done,
  output logic                 miso_o,
  output logic                 miso_oe
);
  logic [1:0]              sck_sync;
  logic [1:0]              cs_sync;
  logic                    sck_prev;
  logic                    cs_prev;
  logic [BITS-1:0]         shreg;
  logic [$clog2(BITS):0]   rises;

  assign load_req = cs_prev && !cs_sync[1];
  assign miso_o   = shreg[BITS-1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sck_sync <= 2'h0;
      cs_sync  <= 2'h3;
      sck_prev <= 1'b0;
      cs_prev  <= 1'b1;
    end else begin
      sck_sync <= {sck_sync[0], spi_sck};
      cs_sync  <= {cs_sync[0], spi_cs_n};
      sck_prev <= sck_sync[1];
      cs_prev  <= cs_sync[1];
    end
  end

  // Most significant bit leaves first
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shreg   <= '0;
      rises   <= '0;
      done    <= 1'b0;
      miso_oe <= 1'b0;
    end else begin
      done    <= 1'b0;
      miso_oe <= !cs_sync[1];
      if (load_req) begin
        shreg <= tx_word;
        rises <= '0;
      end else if (!cs_sync[1]) begin
        if (!sck_prev && sck_sync[1]) begin
          rises <= rises + 1'b1;
        end
        if (sck_prev && !sck_sync[1]) begin
          shreg <= {shreg[BITS-2:0], 1'b0};
        end
      end
      // A frame counts only when exactly all bits were clocked
      if (!cs_prev && cs_sync[1]) begin
        done <= (rises == ($clog2(BITS)+1)'(BITS));
      end
    end
  end
endmodule
`default_nettype wire

// ### hdl/pager_decoder_host_packets.sv
// Decoder-to-host packet framer: picks, formats and ships 32-bit packets over SPI.
// Assumes a 100 MHz hclk, AHB-Lite register access, and a host SPI master.
// Contract
// - Packets leave most significant bit first; byte 3 bit 7 is bit 31.
// - Checksum-disabled decoder sends only the part identification packet.
// - Over-the-air data packets queue in a 32-entry transmit buffer.
// - A pending receiver shutdown packet goes ahead of all others.
// - Otherwise a pending roaming status packet goes next.
// - Otherwise oldest buffer entry, else the unbuffered status packet.
// - Buffer overflow stops decoding and flushes the buffer.
// - First block info word stays internal, except collapse in manual mode.
// - Time forward enable passes time block info words 2-4.
// - All forward enable passes errored and time block info words 2-4.
// - With either enable, errored block info words pass with error flag.
// - Vector and message words of system-message block info are not decoded.
// - Block info packet: id 0, error/phase/format, 14 info bits.
// - Error flag on more than 2 bit errors or failed check character.
// - Phase field codes a, b, c, d as 0 to 3.
// - Error-free forwarded block info words 2-4 carry format 001, 010 or 101.
// - Format type selects the meaning of the information bits.
// - Address packet only for under three errors and an enabled match.
// - Address packet: id 1, flags, phase, match index, vector position.
// - Match index ranges per address kind; long address reported once.
// - Tone-only address has no vector word; position is invalid.
// - Priority flag set for addresses received as priority.
`default_nettype none
module pager_decoder_host_packets #(
  parameter int          BUF_DEPTH = pager_pkt_pkg::TX_BUF_DEPTH,
  parameter logic [31:0] PART_ID   = 32'hA5A5_0001  // Arbitrary identification value
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Block information words from the word decoder
  input  wire logic        biw_valid,
  input  wire logic [1:0]  biw_word_num,
  input  wire logic [1:0]  biw_phase,
  input  wire logic [2:0]  biw_format,
  input  wire logic [13:0] biw_info,
  input  wire logic [2:0]  biw_bit_errors,
  input  wire logic        biw_check_fail,
  // Address words from the address matcher
  input  wire logic        addr_valid,
  input  wire logic [2:0]  addr_bit_errors,
  input  wire logic        addr_match,
  input  wire logic        addr_long_first,
  input  wire logic        priority_flag,
  input  wire logic [1:0]  addr_phase,
  input  wire logic        long_addr_flag,
  input  wire logic        tone_only_flag,
  input  wire logic [7:0]  match_index,
  input  wire logic [6:0]  vector_word_position,
  // Vector and message packets, already formatted upstream
  input  wire logic        data_valid,
  input  wire logic [31:0] data_packet,
  // Decoder steering
  output logic             decode_enable,
  output logic             sys_msg_skip,
  output logic             vector_skip,
  // SPI link
  input  wire logic        spi_sck,
  input  wire logic        spi_cs_n,
  output logic             spi_miso_o,
  output logic             spi_miso_oe
);
  localparam int CW = $clog2(BUF_DEPTH + 1);

  // Register state
  logic [pager_pkt_pkg::CTL_WIDTH-1:0] control;
  logic [31:0]                         shutdown_pkt;
  logic [31:0]                         roaming_pkt;
  logic [31:0]                         status_pkt;
  logic                                shut_pend;
  logic                                roam_pend;
  logic                                stopped;

  // Bus data phase
  logic        dp_write;
  logic [7:0]  dp_ofs;
  logic        addr_phase_ok;

  // Packet path
  logic                    biw_err;
  logic                    biw_fwd;
  logic                    addr_fwd;
  logic                    push;
  logic [31:0]             push_word;
  logic                    overflow;
  logic                    pop;
  logic [31:0]             head;
  logic [CW-1:0]           count;
  logic                    empty;
  logic                    full;
  logic                    load_req;
  logic                    done;
  logic [31:0]             tx_word;
  pager_pkt_pkg::pkt_src_t tx_src;
  pager_pkt_pkg::pkt_src_t sel_src;

  logic ctl_on;
  logic ctl_time_fwd;
  logic ctl_all_fwd;
  logic ctl_manual;
  logic ctl_chk_off;

  assign ctl_on       = control[pager_pkt_pkg::CTL_DECODER_ON];
  assign ctl_time_fwd = control[pager_pkt_pkg::CTL_TIME_FWD];
  assign ctl_all_fwd  = control[pager_pkt_pkg::CTL_ALL_FWD];
  assign ctl_manual   = control[pager_pkt_pkg::CTL_MANUAL_COLL];
  assign ctl_chk_off  = control[pager_pkt_pkg::CTL_CHK_DISABLED];

  assign hreadyout     = 1'b1;
  assign hresp         = 1'b0;
  assign addr_phase_ok = hsel && htrans[1] && hready;

  // Register access: zero wait states, read data registered in the address phase
  // Only the low address byte is decoded; unmapped offsets read zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write <= 1'b0;
      dp_ofs   <= 8'h00;
    end else begin
      dp_write <= addr_phase_ok && hwrite;
      dp_ofs   <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_phase_ok && !hwrite) begin
      hrdata <= 32'h0000_0000;
      unique case (haddr[7:0])
        pager_pkt_pkg::OFS_CONTROL: begin
          hrdata[pager_pkt_pkg::CTL_WIDTH-1:0] <= control;
        end
        pager_pkt_pkg::OFS_STATUS: begin
          hrdata[pager_pkt_pkg::STS_STOPPED]   <= stopped;
          hrdata[pager_pkt_pkg::STS_SHUT_PEND] <= shut_pend;
          hrdata[pager_pkt_pkg::STS_ROAM_PEND] <= roam_pend;
          hrdata[pager_pkt_pkg::STS_COUNT_LSB +: CW] <= count;
        end
        pager_pkt_pkg::OFS_SHUTDOWN: hrdata <= shutdown_pkt;
        pager_pkt_pkg::OFS_ROAMING:  hrdata <= roaming_pkt;
        pager_pkt_pkg::OFS_STAT_PKT: hrdata <= status_pkt;
        default:                     hrdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      control      <= '0;
      shutdown_pkt <= 32'h0000_0000;
      roaming_pkt  <= 32'h0000_0000;
      status_pkt   <= 32'h0000_0000;
    end else if (dp_write) begin
      unique case (dp_ofs)
        pager_pkt_pkg::OFS_CONTROL:  control <= hwdata[pager_pkt_pkg::CTL_WIDTH-1:0];
        pager_pkt_pkg::OFS_SHUTDOWN: shutdown_pkt <= hwdata;
        pager_pkt_pkg::OFS_ROAMING:  roaming_pkt <= hwdata;
        pager_pkt_pkg::OFS_STAT_PKT: status_pkt <= hwdata;
        default: ;
      endcase
    end
  end

  // Pending flags: a software write sets, a completed transfer clears; set wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shut_pend <= 1'b0;
    end else if (dp_write && dp_ofs == pager_pkt_pkg::OFS_SHUTDOWN) begin
      shut_pend <= 1'b1;
    end else if (done && tx_src == pager_pkt_pkg::SRC_SHUTDOWN) begin
      shut_pend <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      roam_pend <= 1'b0;
    end else if (dp_write && dp_ofs == pager_pkt_pkg::OFS_ROAMING) begin
      roam_pend <= 1'b1;
    end else if (done && tx_src == pager_pkt_pkg::SRC_ROAMING) begin
      roam_pend <= 1'b0;
    end
  end

  // Overflow latches a stop until software writes one to the stop bit
  // The overflowing packet is dropped along with the flushed ones
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stopped <= 1'b0;
    end else if (overflow) begin
      stopped <= 1'b1;
    end else if (dp_write && dp_ofs == pager_pkt_pkg::OFS_STATUS
                 && hwdata[pager_pkt_pkg::STS_STOPPED]) begin
      stopped <= 1'b0;
    end
  end

  assign decode_enable = ctl_on && !ctl_chk_off && !stopped;

  // Block information words
  assign biw_err = pager_pkt_pkg::word_in_error(biw_bit_errors, biw_check_fail);

  always_comb begin
    biw_fwd = 1'b0;
    if (biw_word_num == 2'h0) begin
      biw_fwd = ctl_manual;
    end else if (biw_err) begin
      biw_fwd = ctl_time_fwd || ctl_all_fwd;
    end else if (pager_pkt_pkg::is_time_format(biw_format)) begin
      // Other formats never leave with a clear error flag
      biw_fwd = ctl_time_fwd || ctl_all_fwd;
    end
  end

  // Vector and message words of a data/system message frame are not decoded
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sys_msg_skip <= 1'b0;
    end else begin
      sys_msg_skip <= biw_valid && decode_enable && !biw_err
                      && biw_format == pager_pkt_pkg::FMT_SYS_MSG;
    end
  end

  // Address words: errors below three, enabled match, long address reported once
  assign addr_fwd = addr_valid && addr_match && !addr_long_first
                    && (addr_bit_errors <= pager_pkt_pkg::MAX_CORRECTED);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vector_skip <= 1'b0;
    end else begin
      vector_skip <= decode_enable && addr_fwd && tone_only_flag;
    end
  end

  // One packet per cycle enters the buffer; block info has precedence
  // Upstream spaces its events; a second one in the same cycle is lost
  always_comb begin
    push      = 1'b0;
    push_word = 32'h0000_0000;
    if (decode_enable) begin
      if (biw_valid && biw_fwd) begin
        push      = 1'b1;
        push_word = {pager_pkt_pkg::ID_BIW, biw_err, biw_phase, 2'b00,
                     biw_format, 2'b00, biw_info};
      end else if (addr_fwd) begin
        push      = 1'b1;
        push_word = {pager_pkt_pkg::ID_ADDR, priority_flag, addr_phase, long_addr_flag,
                     4'h0, match_index, tone_only_flag,
                     vector_word_position};
      end else if (data_valid) begin
        push      = 1'b1;
        push_word = data_packet;
      end
    end
  end

  assign overflow = push && full;
  assign pop      = done && tx_src == pager_pkt_pkg::SRC_BUFFER;

  pkt_fifo #(
    .WIDTH (pager_pkt_pkg::PKT_BITS),
    .DEPTH (BUF_DEPTH)
  ) u_tx_buf (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .push      (push && !full),
    .push_data (push_word),
    .pop       (pop && !overflow),
    .flush     (overflow),
    .head      (head),
    .count     (count),
    .empty     (empty),
    .full      (full)
  );

  // Packet selection at the start of each frame
  // A write landing mid-frame only takes effect in the next frame
  always_comb begin
    if (ctl_chk_off) begin
      sel_src = pager_pkt_pkg::SRC_PART_ID;
      tx_word = PART_ID;
    end else if (shut_pend) begin
      sel_src = pager_pkt_pkg::SRC_SHUTDOWN;
      tx_word = shutdown_pkt;
    end else if (roam_pend) begin
      sel_src = pager_pkt_pkg::SRC_ROAMING;
      tx_word = roaming_pkt;
    end else if (!empty) begin
      sel_src = pager_pkt_pkg::SRC_BUFFER;
      tx_word = head;
    end else begin
      sel_src = pager_pkt_pkg::SRC_STATUS;
      tx_word = status_pkt;
    end
  end

  // Source is remembered so only the sent item is retired after the frame
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_src <= pager_pkt_pkg::SRC_STATUS;
    end else if (load_req) begin
      tx_src <= sel_src;
    end else if (overflow && tx_src == pager_pkt_pkg::SRC_BUFFER) begin
      // A flushed entry must not be popped later
      tx_src <= pager_pkt_pkg::SRC_STATUS;
    end
  end

  spi_pkt_shifter #(
    .BITS (pager_pkt_pkg::PKT_BITS)
  ) u_shifter (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .spi_sck  (spi_sck),
    .spi_cs_n (spi_cs_n),
    .tx_word  (tx_word),
    .load_req (load_req),
    .done     (done),
    .miso_o   (spi_miso_o),
    .miso_oe  (spi_miso_oe)
  );
endmodule
`default_nettype wire

// ### tb/host_pkt_sva.sv
// Checker for the host packet framer: skip pulses and SPI frame behaviour.
// Bound to the framer top module; sees only its ports.
`default_nettype none
module host_pkt_sva (
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       biw_valid,
  input wire logic [1:0] biw_word_num,
  input wire logic [2:0] biw_format,
  input wire logic [2:0] biw_bit_errors,
  input wire logic       biw_check_fail,
  input wire logic       addr_valid,
  input wire logic [2:0] addr_bit_errors,
  input wire logic       addr_match,
  input wire logic       addr_long_first,
  input wire logic       tone_only_flag,
  input wire logic       decode_enable,
  input wire logic       sys_msg_skip,
  input wire logic       vector_skip,
  input wire logic       spi_sck,
  input wire logic       spi_cs_n,
  input wire logic       spi_miso_o,
  input wire logic       spi_miso_oe
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_msg_skip: assert property (biw_valid && biw_word_num != 2'h0 && biw_format == 3'h5
    && biw_bit_errors <= 3'h2 && !biw_check_fail && decode_enable |=> sys_msg_skip)
    else $error("message skip missing");
  chk_skip_cause: assert property (sys_msg_skip |-> $past(biw_valid)
    && $past(biw_format) == 3'h5) else $error("message skip without cause");
  chk_tone_skip: assert property (addr_valid && !biw_valid && decode_enable
    && tone_only_flag && addr_match && addr_bit_errors <= 3'h2 && !addr_long_first
    |=> vector_skip) else $error("vector skip missing");
  chk_vskip_errs: assert property (addr_valid && addr_bit_errors > 3'h2
    |=> !vector_skip) else $error("vector skip on bad address");
  chk_oe_rise: assert property ($fell(spi_cs_n) |-> ##[1:6] spi_miso_oe)
    else $error("miso not driven in frame");
  chk_oe_hold: assert property (!spi_cs_n && spi_miso_oe |=> spi_miso_oe)
    else $error("miso released in frame");
  chk_oe_idle: assert property (spi_cs_n [*6] |-> !spi_miso_oe)
    else $error("miso driven between frames");
  chk_miso_hold: assert property (spi_sck [*5] |-> $stable(spi_miso_o))
    else $error("miso moved while clock high");
  cover property (sys_msg_skip);
  cover property (vector_skip);
  cover property ($fell(spi_cs_n));
endmodule
bind pager_decoder_host_packets host_pkt_sva u_sva (.*);
`default_nettype wire

// ### tb/spi_host.sv
// Host SPI master model: reads decoder packets in mode 0.
// Assumes the framer drives miso only while its enable is high.
`default_nettype none
module spi_host (
  output var logic spi_sck,
  output var logic spi_cs_n,
  input wire logic spi_miso_o,
  input wire logic spi_miso_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic last = 1'h0;
  initial begin
    spi_sck = 1'h0;
    spi_cs_n = 1'h1;
  end
  // Clock stands still outside frames; a short frame leaves the packet queued
  task automatic xfer(input int nbits, output logic [31:0] w);
    w = 32'h0;
    // Non-blocking, so the framer never races its own sampling edge
    spi_cs_n <= 1'h0;
    #100;
    repeat (nbits) begin
      spi_sck <= 1'h1;
      // A released line must not look like a held bit
      last = spi_miso_oe ? spi_miso_o : ~last;
      w = {w[30:0], last};
      #62.5;
      spi_sck <= 1'h0;
      #62.5;
    end
    spi_cs_n <= 1'h1;
    #200;
  endtask
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench for the host packet framer.
// Drives AHB-Lite, decoder events and an SPI host model.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] PID  = 32'h5A5A_0C3E;  // Arbitrary value
  localparam logic [31:0] STAT = 32'h8124_6E35;
  localparam logic [31:0] SHUT = 32'h96E1_7B2D;
  localparam logic [31:0] M    = 32'hFFFF_FFFF;
  localparam logic [7:0]  CTL  = pager_pkt_pkg::OFS_CONTROL;
  localparam logic [7:0]  STS  = pager_pkt_pkg::OFS_STATUS;
  localparam logic        Y    = 1'h1;
  localparam logic        N    = 1'h0;
  logic        hclk = N, hresetn = N, hsel = N, hwrite = N, hready, hreadyout, hresp;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, data_packet = 32'h0;
  logic [1:0]  htrans = 2'h0, biw_word_num = 2'h0, biw_phase = 2'h0, addr_phase = 2'h0;
  logic [2:0]  hsize = 3'h2, biw_format = 3'h0, biw_bit_errors = 3'h0, addr_bit_errors = 3'h0;
  logic [13:0] biw_info = 14'h0;
  logic        biw_valid = N, biw_check_fail = N, addr_valid = N, addr_match = N;
  logic        addr_long_first = N, priority_flag = N, long_addr_flag = N;
  logic        tone_only_flag = N, data_valid = N;
  logic [7:0]  match_index = 8'h0;
  logic [6:0]  vector_word_position = 7'h0;
  logic        decode_enable, sys_msg_skip, vector_skip, spi_sck, spi_cs_n;
  logic        spi_miso_o, spi_miso_oe;
  int          fails = 0;
  int          checked = 0;
  assign hready = hreadyout;
  always #5 hclk = ~hclk;
  pager_decoder_host_packets #(.PART_ID(PID)) u_dut (.*);
  spi_host u_host (.*);

  task automatic cmp(input string what, input logic [31:0] exp, got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel <= Y;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hready !== Y);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== Y);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    bus(Y, a, d, rd);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, mask, input string what);
    logic [31:0] rd;
    bus(N, a, 32'h0, rd);
    cmp(what, exp & mask, rd & mask);
  endtask
  task automatic rx(input logic [31:0] exp, mask);
    logic [31:0] w;
    u_host.xfer(32, w);
    cmp("packet", exp & mask, w & mask);
  endtask
  task automatic ev_data(input logic [31:0] d);
    @(posedge hclk);
    data_valid <= Y;
    data_packet <= d;
    @(posedge hclk);
    data_valid <= N;
  endtask
  task automatic biw_case(input logic [3:0] ctl, input logic [1:0] num,
                          input logic [2:0] fmt, errs, input logic chk, fwd);
    wr(CTL, {28'h0, ctl});
    @(posedge hclk);
    biw_valid <= Y;
    biw_word_num <= num;
    biw_phase <= ~num;
    biw_format <= fmt;
    biw_bit_errors <= errs;
    biw_check_fail <= chk;
    biw_info <= 14'h2C93;
    @(posedge hclk);
    biw_valid <= N;
    rdc(STS, {23'h0, fwd, 8'h0}, 32'h3F00, "biw count");
    if (fwd) rx({8'h00, (errs > 3'h2) || chk, ~num, 2'h0, fmt, 2'h0, 14'h2C93}, 32'hFFE7_3FFF);
  endtask
  task automatic addr_case(input logic first, input logic [2:0] errs,
                           input logic match, tone, pri, lng, input logic [7:0] idx, input logic fwd);
    @(posedge hclk);
    addr_valid <= Y;
    addr_long_first <= first;
    addr_bit_errors <= errs;
    addr_match <= match;
    tone_only_flag <= tone;
    priority_flag <= pri;
    long_addr_flag <= lng;
    match_index <= idx;
    addr_phase <= idx[1:0];
    vector_word_position <= 7'h2B;
    @(posedge hclk);
    addr_valid <= N;
    rdc(STS, {23'h0, fwd, 8'h0}, 32'h3F00, "addr count");
    if (fwd) rx({8'h01, pri, idx[1:0], lng, 4'h0, idx, tone, 7'h2B},
                tone ? 32'hFFF0_FF80 : 32'hFFF0_FFFF);
  endtask

  task automatic t_base();
    rdc(STS, 32'h0, M, "status");
    rdc(8'h40, 32'h0, M, "unmapped");
    cmp("ready and resp", 32'h2, {30'h0, hreadyout, hresp});
    wr(pager_pkt_pkg::OFS_STAT_PKT, STAT);
    rx(STAT, M);
    $display("t_base done");
  endtask
  task automatic t_partid();
    wr(CTL, (32'h1 << pager_pkt_pkg::CTL_CHK_DISABLED) | 32'h1);
    wr(pager_pkt_pkg::OFS_SHUTDOWN, SHUT);
    rx(PID, M);
    cmp("decode_enable", 32'h0, {31'h0, decode_enable});
    wr(CTL, 32'h1);
    rx(SHUT, M);
    $display("t_partid done");
  endtask
  task automatic t_prio();
    logic [31:0] w;
    ev_data(32'hC3A5_0F1E);
    wr(pager_pkt_pkg::OFS_ROAMING, 32'h5AF0_7711);
    wr(pager_pkt_pkg::OFS_SHUTDOWN, SHUT);
    rdc(STS, 32'h0106, 32'h3F06, "pending");
    rx(SHUT, M);
    rx(32'h5AF0_7711, M);
    u_host.xfer(16, w);
    rx(32'hC3A5_0F1E, M);
    rx(STAT, M);
    $display("t_prio done");
  endtask
  task automatic t_biw();
    biw_case(4'h3, 2'h1, 3'h1, 3'h0, N, Y);
    biw_case(4'h3, 2'h2, 3'h0, 3'h0, N, N);
    biw_case(4'h3, 2'h3, 3'h3, 3'h3, N, Y);
    biw_case(4'h5, 2'h1, 3'h7, 3'h0, Y, Y);
    biw_case(4'h5, 2'h2, 3'h5, 3'h0, N, Y);
    biw_case(4'h1, 2'h1, 3'h2, 3'h0, N, N);
    biw_case(4'h3, 2'h0, 3'h2, 3'h0, N, N);
    biw_case(4'h9, 2'h0, 3'h5, 3'h0, N, Y);
    biw_case(4'h3, 2'h1, 3'h2, 3'h2, N, Y);
    $display("t_biw done");
  endtask
  task automatic t_addr();
    wr(CTL, 32'h1);
    addr_case(N, 3'h2, Y, N, Y, N, 8'h05, Y);
    addr_case(N, 3'h3, Y, N, N, N, 8'h03, N);
    addr_case(N, 3'h0, N, N, N, N, 8'h02, N);
    addr_case(N, 3'h1, Y, Y, N, N, 8'h8F, Y);
    addr_case(Y, 3'h0, Y, N, N, Y, 8'h90, N);
    addr_case(N, 3'h0, Y, N, N, Y, 8'h91, Y);
    $display("t_addr done");
  endtask
  task automatic t_over();
    for (int i = 0; i < 32; i++) ev_data(32'hD000_0000 + 32'(i));
    rdc(STS, 32'h2000, 32'h3F01, "fill");
    ev_data(32'hE000_0020);
    rdc(STS, 32'h1, 32'h3F01, "overflow");
    cmp("decode_enable", 32'h0, {31'h0, decode_enable});
    wr(STS, 32'h1);
    @(posedge hclk);
    cmp("decode_enable", 32'h1, {31'h0, decode_enable});
    $display("t_over done");
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= Y;
    t_base();
    t_partid();
    t_prio();
    t_biw();
    t_addr();
    t_over();
    stop_test();
  end
  // About seven times the expected run length of some 75 us
  initial begin
    #500_000;
    fails++;
    stop_test();
  end
endmodule
`default_nettype wire
